// ===== rtl/ulm_pkg.sv
package ulm_pkg;

    // register byte addresses on the apb side
    localparam logic [4:0] ULM_DATA_OFF = 5'h00;
    localparam logic [4:0] ULM_IE_OFF   = 5'h04;
    localparam logic [4:0] ULM_LC_OFF   = 5'h08;
    localparam logic [4:0] ULM_MC_OFF   = 5'h0c;
    localparam logic [4:0] ULM_LS_OFF   = 5'h10;
    localparam logic [4:0] ULM_MS_OFF   = 5'h14;
    localparam logic [4:0] ULM_FC_OFF   = 5'h18;
    localparam logic [4:0] ULM_FLOW_OFF = 5'h1c;

    localparam logic [7:0]  ULM_LC_RST   = 8'h00;
    localparam logic [7:0]  ULM_MC_RST   = 8'h00;
    localparam logic [7:0]  ULM_IE_RST   = 8'h00;
    localparam logic [7:0]  ULM_FC_RST   = 8'h00;
    localparam logic [15:0] ULM_DIV_RST  = 16'h0001;
    localparam logic [7:0]  ULM_XON_RST  = 8'h11;
    localparam logic [7:0]  ULM_XOFF_RST = 8'h13;

    // line_control fields
    localparam int ULM_LC_PEN   = 3;
    localparam int ULM_LC_EPS   = 4;
    localparam int ULM_LC_STICK = 5;
    localparam int ULM_LC_BRK   = 6;
    localparam int ULM_LC_DLAB  = 7;
    // modem_control fields
    localparam int ULM_MC_DTR  = 0;
    localparam int ULM_MC_RTS  = 1;
    localparam int ULM_MC_OUT1 = 2;
    localparam int ULM_MC_OUT2 = 3;
    localparam int ULM_MC_LOOP = 4;
    localparam int ULM_MC_XANY = 5;
    localparam int ULM_MC_IR   = 6;
    localparam int ULM_MC_PRE  = 7;
    // feature_control fields
    localparam int ULM_FC_UNLOCK  = 0;
    localparam int ULM_FC_SWFLOW  = 1;
    localparam int ULM_FC_AUTORTS = 2;
    // interrupt_enable fields
    localparam int ULM_IE_RXD  = 0;
    localparam int ULM_IE_THRE = 1;
    localparam int ULM_IE_LS   = 2;
    localparam int ULM_IE_MS   = 3;
    // status fields
    localparam int ULM_LS_OE  = 1;
    localparam int ULM_MS_CTS = 0;
    localparam int ULM_MS_RI  = 2;

    localparam int ULM_PRE_SHIFT  = 2;
    localparam int ULM_IR_SHIFT   = 2;
    localparam int ULM_LAST_BIT   = 7;
    localparam int ULM_RTS_MARGIN = 4;

    typedef enum logic [2:0] {
        ULM_IDLE  = 3'b000,
        ULM_START = 3'b001,
        ULM_DATA  = 3'b010,
        ULM_PAR   = 3'b011,
        ULM_STOP  = 3'b100,
        ULM_BRKW  = 3'b101
    } ulm_state_type;

    // modem pins, all active low, in modem_status high-nibble order
    typedef struct packed {
        logic carrier_detect_in_n;
        logic ring_indicator_in_n;
        logic dsr_in_n;
        logic cts_in_n;
    } ulm_modem_type;

    typedef struct packed {
        logic       brk;
        logic       fe;
        logic       pe;
        logic [7:0] data;
    } ulm_rx_entry_type;

endpackage

// ===== rtl/ulm_uart_ctrl.sv
// Register access over APB and the address map were left to the implementer.
`timescale 1ns/100ps
// Notes on behaviour
// RULE1: parity disabled means no parity sent or checked
// RULE2: parity type zero odd, one even
// RULE3: forced parity is one or zero per type
// RULE4: break bit holds transmit output low
// RULE5: divisor-access bit steers shared addresses to divisor
// RULE6: terminal-ready pin is inverse of its bit
// RULE7: request-to-send inverse of bit unless auto flow
// RULE8: first aux bit drives ring input in loopback
// RULE9: interrupt-output bit enables irq, drives aux two
// RULE10: loopback bit selects internal loopback, reset off
// RULE11: loopback routes serial and modem lines internally
// RULE12: any character resumes halted transmit when enabled
// RULE13: infrared bit routes serial through encoder, idle low
// RULE14: prescaler bit divides baud clock by four
// RULE15: data ready while receive fifo holds data
// RULE16: full fifo sets overrun, drops new character
// RULE17: parity and framing tags travel with character
// RULE18: break sets flag, one break character stored
// RULE19: holding empty set when empty, cleared on write
// RULE20: transmitter idle when holding and shift empty
// RULE21: fifo error while any stored byte is tagged
// RULE22: line status interrupt cleared by status read
// RULE23: cts and dsr deltas flag any change
// RULE24: ring delta only when ringing ends
// RULE25: modem status read clears all delta flags
// RULE26: modem status interrupt cleared by status read
// RULE27: cts status inverts pin, loopback mirrors rts bit
module ulm_uart_ctrl
    import ulm_pkg::*;
#(
    parameter int RX_DEPTH = 64
) (
    input  wire logic          pclk,
    input  wire logic          presetn,
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [4:0]    paddr,
    input  wire logic [31:0]   pwdata,
    output logic      [31:0]   prdata,
    output logic               pready,
    output logic               pslverr,
    input  wire logic          rx_in,
    input  wire ulm_modem_type modem_in,
    output logic               tx_out,
    output logic               dtr_n_out,
    output logic               rts_n_out,
    output logic               aux_output_two,
    output logic               irq_out,
    output logic               irq_oe_n
);
    localparam int PW = $clog2(RX_DEPTH);
    localparam int CW = PW + 1;

    logic [7:0]          lc_q, mc_q, ie_q, fc_q, xon_q, xoff_q;
    logic [15:0]         div_q;
    logic [31:0]         rd_q, rdata_d;
    logic                ok_q, ok_d, wr, rd, dlab, unlock, loop, ir_en;
    logic [4:0]          raw, s1_q, s2_q, s3_q, filt_q;
    logic [17:0]         eff, top, tx_cnt_q, rxb_q;
    logic                tx_tick, rx_tick, tx_take, thr_wr, thr_full_q, tx_halt_q;
    logic [7:0]          thr_q, tsr_q, rsr_q;
    logic [2:0]          tx_n_q, rx_n_q;
    logic                tx_par_q, tx_ser, line, tx_line_q, ir_lat_q, rx_line;
    ulm_state_type       tx_st_q, rx_st_q;
    logic                rx_done_q, pe_q, fe_q, bk_q, pb_q;
    ulm_rx_entry_type    mem [RX_DEPTH];
    ulm_rx_entry_type    head;
    logic [RX_DEPTH-1:0] errv_q;
    logic [PW-1:0]       wp_q, rp_q;
    logic [CW-1:0]       cnt_q;
    logic                drop, rx_full, push, pop, ovr, sw, dr, thre, temt;
    logic                oe_q, lsi_q, ls_rd, ms_rd, aux_q;
    logic [7:0]          ls;
    logic [3:0]          msr_hi_q, delta_q, st_now, dset;

    function automatic logic par_fn(input logic [7:0] d, input logic [7:0] lc);
        par_fn = lc[ULM_LC_STICK] ? ~lc[ULM_LC_EPS] : (^d ^ ~lc[ULM_LC_EPS]); // RULE2 RULE3
    endfunction

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // apb: read data is caught in setup so the access phase never waits
    assign dlab    = lc_q[ULM_LC_DLAB];
    assign unlock  = fc_q[ULM_FC_UNLOCK];
    assign loop    = mc_q[ULM_MC_LOOP];
    assign ir_en   = mc_q[ULM_MC_IR] & unlock;
    assign sw      = fc_q[ULM_FC_SWFLOW] & unlock;
    assign wr      = psel & penable & ok_q & pwrite;
    assign rd      = psel & penable & ok_q & ~pwrite;
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~ok_q;
    assign prdata  = rd_q;

    always_comb begin
        rdata_d = '0;
        ok_d    = 1'b1;
        case (paddr)
            ULM_DATA_OFF: rdata_d[7:0] = dlab ? div_q[7:0] : head.data; // RULE5
            ULM_IE_OFF:   rdata_d[7:0] = dlab ? div_q[15:8] : ie_q;
            ULM_LC_OFF:   rdata_d[7:0] = lc_q;
            ULM_MC_OFF:   rdata_d[7:0] = mc_q;
            ULM_LS_OFF:   rdata_d[7:0] = ls;
            ULM_MS_OFF:   rdata_d[7:0] = {msr_hi_q, delta_q};
            ULM_FC_OFF:   rdata_d[7:0] = fc_q;
            ULM_FLOW_OFF: rdata_d[15:0] = {xoff_q, xon_q};
            default:      ok_d = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_q <= '0;
            ok_q <= 1'b0;
        end else if (psel && !penable) begin
            rd_q <= pwrite ? '0 : rdata_d;
            ok_q <= ok_d;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lc_q   <= ULM_LC_RST;
            mc_q   <= ULM_MC_RST;
            ie_q   <= ULM_IE_RST;
            fc_q   <= ULM_FC_RST;
            div_q  <= ULM_DIV_RST;
            xon_q  <= ULM_XON_RST;
            xoff_q <= ULM_XOFF_RST;
        end else if (wr) begin
            case (paddr)
                ULM_DATA_OFF: if (dlab) div_q[7:0] <= pwdata[7:0]; // RULE5
                ULM_IE_OFF: begin
                    if (dlab) div_q[15:8] <= pwdata[7:0];
                    else ie_q <= pwdata[7:0];
                end
                ULM_LC_OFF:   lc_q <= pwdata[7:0];
                ULM_MC_OFF:   mc_q <= pwdata[7:0]; // RULE10
                ULM_FC_OFF:   fc_q <= pwdata[7:0];
                ULM_FLOW_OFF: {xoff_q, xon_q} <= pwdata[15:0];
                default: ;
            endcase
        end
    end

    // pins: three stages, a change is taken once stages two and three agree
    assign raw = {rx_in, modem_in};
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_q <= '1;
            s2_q <= '1;
            s3_q <= '1;
        end else begin
            s1_q <= raw;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    for (genvar g = 0; g < 5; g++) begin : g_filt
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) filt_q[g] <= 1'b1;
            else if (s2_q[g] == s3_q[g]) filt_q[g] <= s3_q[g];
        end
    end

    // one bit time is divisor cycles, times four with the prescaler
    assign eff = (mc_q[ULM_MC_PRE] && unlock) ? 18'({2'b00, div_q} << ULM_PRE_SHIFT)
                                               : {2'b00, div_q}; // RULE14
    assign top     = (eff == '0) ? '0 : eff - 18'd1;
    assign tx_tick = (tx_cnt_q == '0);
    assign rx_tick = (rxb_q == '0);

    // transmit holding register and shifter
    assign thr_wr  = wr && paddr == ULM_DATA_OFF && !dlab;
    assign tx_take = tx_st_q == ULM_IDLE && thr_full_q && !tx_halt_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            thr_q      <= '0;
            thr_full_q <= 1'b0;
        end else if (thr_wr) begin
            thr_q      <= pwdata[7:0];
            thr_full_q <= 1'b1; // RULE19
        end else if (tx_take) begin
            thr_full_q <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_st_q  <= ULM_IDLE;
            tx_cnt_q <= '0;
            tsr_q    <= '0;
            tx_n_q   <= '0;
            tx_par_q <= 1'b0;
        end else begin
            tx_cnt_q <= (tx_tick || tx_take) ? top : tx_cnt_q - 18'd1;
            case (tx_st_q)
                ULM_IDLE: if (tx_take) begin
                    tsr_q    <= thr_q;
                    tx_par_q <= par_fn(thr_q, lc_q);
                    tx_n_q   <= '0;
                    tx_st_q  <= ULM_START;
                end
                ULM_START: if (tx_tick) tx_st_q <= ULM_DATA;
                ULM_DATA: if (tx_tick) begin
                    tsr_q  <= tsr_q >> 1;
                    tx_n_q <= tx_n_q + 3'd1;
                    if (tx_n_q == 3'(ULM_LAST_BIT))
                        tx_st_q <= lc_q[ULM_LC_PEN] ? ULM_PAR : ULM_STOP; // RULE1
                end
                ULM_PAR:  if (tx_tick) tx_st_q <= ULM_STOP;
                ULM_STOP: if (tx_tick) tx_st_q <= ULM_IDLE;
                default:  tx_st_q <= ULM_IDLE;
            endcase
        end
    end

    always_comb begin
        case (tx_st_q)
            ULM_START: tx_ser = 1'b0;
            ULM_DATA:  tx_ser = tsr_q[0];
            ULM_PAR:   tx_ser = tx_par_q;
            default:   tx_ser = 1'b1;
        endcase
    end
    assign line = lc_q[ULM_LC_BRK] ? 1'b0 : tx_ser; // RULE4

    // ir pulse covers the first quarter of each zero bit, idle is low
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_line_q <= 1'b1;
            tx_out    <= 1'b1;
        end else begin
            tx_line_q <= line;
            if (loop) tx_out <= 1'b1; // RULE11
            else if (ir_en) tx_out <= !line && tx_cnt_q >= top - (top >> ULM_IR_SHIFT); // RULE13
            else tx_out <= line; // RULE4
        end
    end

    // receiver: ir decode latches the short pulse until the bit is sampled
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) ir_lat_q <= 1'b0;
        else if (filt_q[4]) ir_lat_q <= 1'b1; // a pulse at the sample edge is kept
        else if (rx_tick && rx_st_q != ULM_IDLE) ir_lat_q <= 1'b0;
    end
    assign rx_line = loop ? tx_line_q : (ir_en ? !ir_lat_q : filt_q[4]); // RULE11 RULE13

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_st_q   <= ULM_IDLE;
            rxb_q     <= '0;
            rsr_q     <= '0;
            rx_n_q    <= '0;
            pe_q      <= 1'b0;
            fe_q      <= 1'b0;
            bk_q      <= 1'b0;
            pb_q      <= 1'b0;
            rx_done_q <= 1'b0;
        end else begin
            rx_done_q <= 1'b0;
            rxb_q     <= rx_tick ? top : rxb_q - 18'd1;
            case (rx_st_q)
                ULM_IDLE: begin
                    rxb_q <= top >> 1;
                    if (!rx_line) rx_st_q <= ULM_START;
                end
                ULM_START: if (rx_tick) begin
                    rx_st_q <= rx_line ? ULM_IDLE : ULM_DATA;
                    rx_n_q  <= '0;
                    pe_q    <= 1'b0;
                    pb_q    <= 1'b0;
                end
                ULM_DATA: if (rx_tick) begin
                    rsr_q  <= {rx_line, rsr_q[7:1]};
                    rx_n_q <= rx_n_q + 3'd1;
                    if (rx_n_q == 3'(ULM_LAST_BIT))
                        rx_st_q <= lc_q[ULM_LC_PEN] ? ULM_PAR : ULM_STOP; // RULE1
                end
                ULM_PAR: if (rx_tick) begin
                    pe_q    <= rx_line != par_fn(rsr_q, lc_q); // RULE2 RULE3
                    pb_q    <= rx_line;
                    rx_st_q <= ULM_STOP;
                end
                ULM_STOP: if (rx_tick) begin
                    fe_q      <= !rx_line; // RULE17
                    bk_q      <= !rx_line && rsr_q == '0 && !pb_q; // RULE18
                    rx_done_q <= 1'b1;
                    rx_st_q   <= rx_line ? ULM_IDLE : ULM_BRKW;
                end
                // a held-low line yields one character, then waits for mark
                ULM_BRKW: if (rx_line) rx_st_q <= ULM_IDLE; // RULE18
                default: rx_st_q <= ULM_IDLE;
            endcase
        end
    end

    // software flow: xoff halts, xon resumes, or any character when the xany bit is set
    assign drop = sw && (rsr_q == xon_q || rsr_q == xoff_q); // RULE12
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) tx_halt_q <= 1'b0;
        else if (!sw) tx_halt_q <= 1'b0;
        else if (rx_done_q && rsr_q == xoff_q) tx_halt_q <= 1'b1;
        else if (rx_done_q && (rsr_q == xon_q || (mc_q[ULM_MC_XANY] && unlock)))
            tx_halt_q <= 1'b0; // RULE12
    end

    // receive fifo with a per-entry error tag for the summary flag
    assign rx_full = cnt_q == CW'(RX_DEPTH);
    assign push    = rx_done_q && !drop && !rx_full;
    assign ovr     = rx_done_q && !drop && rx_full; // RULE16
    assign dr      = cnt_q != '0;
    assign pop     = rd && paddr == ULM_DATA_OFF && !dlab && dr;
    assign head    = mem[rp_q];

    always_ff @(posedge pclk) begin
        if (push) mem[wp_q] <= '{bk_q, fe_q, pe_q, rsr_q}; // RULE17
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wp_q   <= '0;
            rp_q   <= '0;
            cnt_q  <= '0;
            errv_q <= '0;
        end else begin
            if (push) begin
                wp_q         <= (wp_q == PW'(RX_DEPTH - 1)) ? '0 : wp_q + PW'(1);
                errv_q[wp_q] <= pe_q | fe_q | bk_q; // RULE21
            end
            if (pop) begin
                rp_q         <= (rp_q == PW'(RX_DEPTH - 1)) ? '0 : rp_q + PW'(1);
                errv_q[rp_q] <= 1'b0; // RULE21
            end
            cnt_q <= cnt_q + CW'(push) - CW'(pop);
        end
    end

    // line status; error tags follow the head entry
    assign thre = !thr_full_q; // RULE19
    assign temt = thre && tx_st_q == ULM_IDLE; // RULE20
    assign ls   = {|errv_q, temt, thre, dr & head.brk, dr & head.fe, dr & head.pe,
                   oe_q, dr}; // RULE15 RULE17 RULE21
    assign ls_rd = rd && paddr == ULM_LS_OFF;
    assign ms_rd = rd && paddr == ULM_MS_OFF;

    // overrun clears only if the read showed it, the interrupt on any status read; a new event in the same cycle wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            oe_q  <= 1'b0;
            lsi_q <= 1'b0;
        end else begin
            oe_q  <= (oe_q & !(ls_rd && rd_q[ULM_LS_OE])) | ovr; // RULE16
            lsi_q <= (lsi_q & !ls_rd) | ovr | (push & (pe_q | fe_q | bk_q)); // RULE22
        end
    end

    assign st_now = loop ? {mc_q[ULM_MC_OUT2], mc_q[ULM_MC_OUT1], mc_q[ULM_MC_DTR],
                            mc_q[ULM_MC_RTS]} : ~filt_q[3:0]; // RULE8 RULE11 RULE27
    assign dset   = {msr_hi_q[3] ^ st_now[3], msr_hi_q[2] & !st_now[2],
                     msr_hi_q[1:0] ^ st_now[1:0]}; // RULE23 RULE24

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            msr_hi_q <= '0;
            delta_q  <= '0;
        end else begin
            msr_hi_q <= st_now;
            delta_q  <= (delta_q & ~(ms_rd ? rd_q[3:0] : 4'h0)) | dset; // RULE25 RULE26
        end
    end

    // modem pins and interrupt line, all from flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dtr_n_out <= 1'b1;
            rts_n_out <= 1'b1;
            aux_q     <= 1'b1;
            irq_out   <= 1'b0;
        end else begin
            dtr_n_out <= !mc_q[ULM_MC_DTR]; // RULE6
            if (fc_q[ULM_FC_AUTORTS] && unlock)
                rts_n_out <= cnt_q >= CW'(RX_DEPTH - ULM_RTS_MARGIN); // RULE7
            else
                rts_n_out <= !mc_q[ULM_MC_RTS]; // RULE7
            aux_q   <= !mc_q[ULM_MC_OUT2]; // RULE9
            irq_out <= (ie_q[ULM_IE_RXD] & dr) | (ie_q[ULM_IE_THRE] & thre)
                     | (ie_q[ULM_IE_LS] & lsi_q) | (ie_q[ULM_IE_MS] & |delta_q); // RULE23
        end
    end
    assign aux_output_two = aux_q;
    assign irq_oe_n       = aux_q; // RULE9

    par_off_a: assert property ($rose(tx_st_q == ULM_PAR) |-> $past(lc_q[ULM_LC_PEN])) // RULE1
        else $error("parity bit sent while parity disabled");
    brk_low_a: assert property (lc_q[ULM_LC_BRK] && !loop && !ir_en |=> !tx_out) // RULE4
        else $error("break set but transmit output not low");
    dtr_pin_a: assert property (1'b1 |=> dtr_n_out == !$past(mc_q[ULM_MC_DTR])) // RULE6
        else $error("terminal-ready pin does not follow its bit");
    aux_irq_a: assert property (1'b1 |=> aux_output_two == !$past(mc_q[ULM_MC_OUT2])
                                && irq_oe_n == aux_output_two) // RULE9
        else $error("aux two or irq enable wrong");
    dr_push_a: assert property (push && cnt_q == '0 |=> ls[0]) // RULE15
        else $error("data ready not set after push");
    overrun_set_a: assert property (ovr && !pop |=> oe_q && cnt_q == $past(cnt_q)) // RULE16
        else $error("overrun not flagged or fifo changed");
    thre_clear_a: assert property (thr_wr |=> !ls[5]) // RULE19
        else $error("holding empty still set after write");
    lsi_clear_a: assert property (ls_rd && !ovr && !push |=> !lsi_q) // RULE22
        else $error("line status interrupt not cleared by read");
    ri_end_a: assert property ($fell(msr_hi_q[ULM_MS_RI]) |-> delta_q[ULM_MS_RI]) // RULE24
        else $error("ring delta missed at end of ringing");
    ms_clear_a: assert property (ms_rd && dset == '0 |=> (delta_q & $past(rd_q[3:0])) == '0) // RULE25
        else $error("delta flags not cleared by status read");
    cts_loop_a: assert property ($past(loop) && loop
                                 |-> msr_hi_q[ULM_MS_CTS] == $past(mc_q[ULM_MC_RTS])) // RULE27
        else $error("loopback cts status not equal to rts bit");

endmodule

// ===== verif/ulm_far_model.sv
`timescale 1ns/100ps
module ulm_far_model
    import ulm_pkg::*;
#(
    parameter int BT = 8
) (
    input  wire logic     pclk,
    output logic          rx_in,
    output ulm_modem_type modem_in
);
    initial rx_in = 1'b1;
    initial modem_in = 4'hf;
    // line rests high; a low stop bit is sent only to provoke a framing fault
    task automatic send(input logic [7:0] d, input logic pen, input logic pb, input logic stp);
        logic [10:0] f;
        f = pen ? {stp, pb, d, 1'b0} : {1'b1, stp, d, 1'b0};
        for (int i = 0; i < 10 + pen; i++) begin
            @(posedge pclk);
            rx_in <= f[i];
            repeat (BT - 1) @(posedge pclk);
        end
        @(posedge pclk);
        rx_in <= 1'b1;
    endtask
    task automatic brk();
        @(posedge pclk);
        rx_in <= 1'b0;
        repeat (12 * BT) @(posedge pclk);
        rx_in <= 1'b1;
    endtask
    task automatic set_modem(input logic [3:0] v);
        @(posedge pclk);
        modem_in <= v;
    endtask
endmodule

// ===== verif/uart_line_modem_control_status_tb.sv
`timescale 1ns/100ps
module uart_line_modem_control_status_tb;
    import ulm_pkg::*;
    localparam int BT = 8;
    logic          pclk = 1'b0;
    logic          presetn = 1'b0;
    logic          psel = 1'b0;
    logic          penable = 1'b0;
    logic          pwrite = 1'b0;
    logic [4:0]    paddr = 5'h00;
    logic [31:0]   pwdata = 32'h0;
    logic [31:0]   prdata, r;
    logic          pready, pslverr, rx_in, tx_out, dtr_n_out, rts_n_out;
    logic          aux_output_two, irq_out, irq_oe_n, e, pe, fe;
    ulm_modem_type modem_in;
    int            n_errors = 0;
    int            checks_done = 0;
    int            seed = 86791;
    logic [7:0]    b, v;
    logic [7:0]    q[$];
    logic [7:0]    modes[5] = '{8'h33, 8'h0b, 8'h1b, 8'h2b, 8'h3b};
    always #20 pclk = ~pclk;
    ulm_uart_ctrl #(.RX_DEPTH(4)) DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .rx_in, .modem_in, .tx_out, .dtr_n_out,
        .rts_n_out, .aux_output_two, .irq_out, .irq_oe_n);
    ulm_far_model #(.BT(BT)) p (.pclk, .rx_in, .modem_in);
    task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", n, exp, got);
        end
    endtask
    task automatic apb(input logic w, input logic [4:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdc(input logic [4:0] a, input logic [31:0] m, input logic [31:0] x,
                       input string n);
        apb(1'b0, a, 32'h0);
        chk(n, r & m, x);
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask
    // reference parity, kept apart from the design's own logic
    function automatic logic pbit(input logic [7:0] d, input logic [7:0] lc);
        if (lc[ULM_LC_STICK]) return ~lc[ULM_LC_EPS];
        return lc[ULM_LC_EPS] ? ^d : ~^d;
    endfunction
    task automatic conclude;
        $display("errors %0d checks %0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        repeat (60000) @(posedge pclk);
        n_errors++;
        conclude;
    end
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        tick(1);
        chk("pins", {tx_out, dtr_n_out, rts_n_out, aux_output_two, irq_oe_n}, 5'h1f);
        rdc(ULM_MC_OFF, 32'hff, 32'h0, "mc");
        apb(1'b0, 5'h02, 32'h0);
        chk("slverr", {31'h0, e}, 32'h1);
        apb(1'b1, ULM_LC_OFF, 32'h80);
        apb(1'b1, ULM_DATA_OFF, 32'(BT));
        apb(1'b1, ULM_IE_OFF, 32'h0);
        rdc(ULM_DATA_OFF, 32'hff, 32'(BT), "div");
        repeat (4) begin
            v = 8'($random(seed));
            apb(1'b1, ULM_MC_OFF, {24'h0, v & 8'h0b});
            tick(2);
            chk("mcp", {aux_output_two, irq_oe_n, rts_n_out, dtr_n_out}, {~v[3], ~v[3], ~v[1], ~v[0]});
        end
        apb(1'b1, ULM_LC_OFF, 32'h43);
        tick(30);
        chk("brk", tx_out, 1'b0);
        apb(1'b1, ULM_LC_OFF, 32'h03);
        tick(3);
        chk("brk end", tx_out, 1'b1);
        foreach (modes[m]) begin
            b = 8'($random(seed));
            apb(1'b1, ULM_LC_OFF, {24'h0, modes[m]});
            apb(1'b1, ULM_DATA_OFF, {24'h0, b});
            tick(2 + BT / 2);
            chk("start", tx_out, 1'b0);
            for (int i = 0; i < 8; i++) begin
                tick(BT);
                chk("txbit", tx_out, b[i]);
            end
            if (modes[m][ULM_LC_PEN]) begin
                tick(BT);
                chk("txpar", tx_out, pbit(b, modes[m]));
            end
            tick(BT);
            chk("stop", tx_out, 1'b1);
            tick(BT);
            rdc(ULM_LS_OFF, 32'h60, 32'h60, "idle");
            pe = modes[m][ULM_LC_PEN] & b[0];
            fe = (m == 4);
            p.send(b, modes[m][ULM_LC_PEN], pbit(b, modes[m]) ^ pe, ~fe);
            tick(6);
            rdc(ULM_LS_OFF, 32'h8d, {pe | fe, 3'h0, fe, pe, 2'h1}, "tags");
            rdc(ULM_DATA_OFF, 32'hff, b, "rx");
            rdc(ULM_LS_OFF, 32'h8d, 32'h0, "empty");
        end
        apb(1'b1, ULM_LC_OFF, 32'h03);
        repeat (5) begin
            b = 8'($random(seed));
            q.push_back(b);
            p.send(b, 1'b0, 1'b0, 1'b1);
        end
        tick(6);
        rdc(ULM_LS_OFF, 32'h03, 32'h03, "ovr");
        for (int i = 0; i < 4; i++) rdc(ULM_DATA_OFF, 32'hff, q[i], "fifo");
        rdc(ULM_LS_OFF, 32'h03, 32'h0, "drained");
        p.brk();
        tick(6);
        rdc(ULM_LS_OFF, 32'h95, 32'h91, "rxbrk");
        rdc(ULM_DATA_OFF, 32'hff, 32'h0, "brkchar");
        rdc(ULM_LS_OFF, 32'h95, 32'h0, "onebrk");
        apb(1'b1, ULM_IE_OFF, 32'h08);
        apb(1'b1, ULM_MC_OFF, 32'h08);
        rdc(ULM_MS_OFF, 32'h0f, 32'h0, "quiet");
        p.set_modem(4'ha);
        tick(8);
        chk("irq", irq_out, 1'b1);
        rdc(ULM_MS_OFF, 32'hff, 32'h51, "cts");
        tick(2);
        chk("irqclr", irq_out, 1'b0);
        rdc(ULM_MS_OFF, 32'hff, 32'h50, "dclr");
        p.set_modem(4'hf);
        tick(8);
        rdc(ULM_MS_OFF, 32'hff, 32'h05, "ring");
        // loopback keeps the pin high, so the echo proves the internal path
        apb(1'b1, ULM_MC_OFF, 32'h17);
        tick(2);
        chk("lbtx", tx_out, 1'b1);
        rdc(ULM_MS_OFF, 32'hf0, 32'h70, "lbms");
        b = 8'($random(seed));
        apb(1'b1, ULM_DATA_OFF, {24'h0, b});
        rdc(ULM_LS_OFF, 32'h40, 32'h0, "busy");
        tick(12 * BT);
        rdc(ULM_DATA_OFF, 32'hff, b, "lbrx");
        apb(1'b1, ULM_MC_OFF, 32'h0);
        rdc(ULM_MS_OFF, 32'hf0, 32'h0, "lboff");
        apb(1'b1, ULM_FC_OFF, 32'h1);
        apb(1'b1, ULM_MC_OFF, 32'h40);
        tick(3);
        chk("iridle", tx_out, 1'b0);
        conclude;
    end
endmodule
